// ==== src/flash_host_ctrl.sv ====
// host controller sequencing page writes, commands and status polling on the flash
`timescale 1ns/1ps
`default_nettype none
module flash_host_ctrl #(
    parameter int BYTE_WINDOW_CYC = flash_host_pkg::BYTE_WINDOW_CYC,
    parameter int LOAD_TIMEOUT_CYC = flash_host_pkg::LOAD_TIMEOUT_CYC,
    parameter int ERASE_CYC = flash_host_pkg::ERASE_CYC,
    parameter int POLL_LIMIT = flash_host_pkg::POLL_LIMIT
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // command port
    input wire logic cmd_valid_i,
    input wire logic [2:0] cmd_op_i,
    input wire logic [16:0] cmd_addr_i,
    input wire logic [7:0] cmd_data_i,
    input wire logic protect_i,
    output logic cmd_ready_o,
    // page data port
    input wire logic byte_valid_i,
    input wire logic [6:0] byte_offset_i,
    input wire logic [7:0] byte_data_i,
    input wire logic byte_last_i,
    output logic byte_ready_o,
    // results
    output logic done_o,
    output logic error_o,
    output logic [7:0] rdata_o,
    // flash pins
    output logic [16:0] address_lines_o,
    output logic [7:0] data_lines_o,
    output logic data_lines_oe_o,
    input wire logic [7:0] data_lines_i,
    output logic chip_enable_n_o,
    output logic output_enable_n_o,
    output logic write_enable_n_o,
    output logic id_high_voltage_address_line_o
);
    typedef enum logic [7:0] {
        S_IDLE = 8'b0000_0001,
        S_CMD = 8'b0000_0010,
        S_LOAD = 8'b0000_0100,
        S_WAIT_BYTE = 8'b0000_1000,
        S_POLL = 8'b0001_0000,
        S_PAUSE = 8'b0010_0000,
        S_READ = 8'b0100_0000,
        S_FINISH = 8'b1000_0000
    } host_state_t;
    host_state_t state_r;
    logic [2:0] op_r;
    logic [2:0] step_r;
    logic [2:0] nsteps_r;
    logic [16:0] page_r;
    logic [16:0] raddr_r;
    logic [7:0] last_data_r;
    logic [31:0] timer_r;
    logic [31:0] polls_r;
    logic bc_start_r;
    logic bc_write_r;
    logic [16:0] bc_addr_r;
    logic [7:0] bc_wdata_r;
    logic bc_done;
    logic [7:0] bc_rdata;
    logic bc_oe_n;
    logic prev_toggle_r;
    logic poll_started_r;

    // command sequence table: address and data of one step
    function automatic logic [24:0] seq_step(input logic [2:0] op, input logic [2:0] step);
        logic [7:0] d;
        logic [16:0] a;
        d = flash_host_pkg::DATA_AA;
        a = (step == 3'd1 || step == 3'd4) ? flash_host_pkg::ADDR_2AAA : flash_host_pkg::ADDR_5555;
        if (step == 3'd1 || step == 3'd4) begin
            d = flash_host_pkg::DATA_55;
        end else if (step == 3'd2) begin
            d = (op == flash_host_pkg::OP_PAGE || op == flash_host_pkg::OP_PROT_ON) ? flash_host_pkg::DATA_A0 :
                (op == flash_host_pkg::OP_ID_EXIT) ? flash_host_pkg::DATA_F0 : flash_host_pkg::DATA_80;
        end else if (step == 3'd5) begin
            d = (op == flash_host_pkg::OP_ERASE) ? flash_host_pkg::DATA_10 :
                (op == flash_host_pkg::OP_ID_ENTER) ? flash_host_pkg::DATA_60 : flash_host_pkg::DATA_20;
        end
        return {a, d};
    endfunction : seq_step

    function automatic logic [2:0] seq_len(input logic [2:0] op, input logic prot);
        case (op)
            flash_host_pkg::OP_PAGE: seq_len = prot ? 3'd3 : 3'd0;
            flash_host_pkg::OP_PROT_ON: seq_len = 3'd3;
            flash_host_pkg::OP_ID_EXIT: seq_len = 3'd3;
            flash_host_pkg::OP_PROT_OFF, flash_host_pkg::OP_ERASE, flash_host_pkg::OP_ID_ENTER: seq_len = 3'd6;
            default: seq_len = 3'd0;
        endcase
    endfunction : seq_len

    flash_bus_cycle u_cycle (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(bc_start_r),
        .write_i(bc_write_r),
        .addr_i(bc_addr_r),
        .wdata_i(bc_wdata_r),
        .done_o(bc_done),
        .rdata_o(bc_rdata),
        .addr_o(address_lines_o),
        .dq_o(data_lines_o),
        .dq_oe_o(data_lines_oe_o),
        .ce_n_o(chip_enable_n_o),
        .oe_n_o(bc_oe_n),
        .we_n_o(write_enable_n_o),
        .dq_i(data_lines_i)
    );

    // output enable follows the bus cycle's oe strobe, registered one clock later
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            output_enable_n_o <= 1'b1;
        end else begin
            output_enable_n_o <= bc_oe_n;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_r <= S_IDLE;
            op_r <= flash_host_pkg::OP_READ;
            step_r <= 3'd0;
            nsteps_r <= 3'd0;
            page_r <= 17'h0_0000;
            raddr_r <= 17'h0_0000;
            last_data_r <= 8'h00;
            timer_r <= 32'h0000_0000;
            polls_r <= 32'h0000_0000;
            bc_start_r <= 1'b0;
            bc_write_r <= 1'b0;
            bc_addr_r <= 17'h0_0000;
            bc_wdata_r <= 8'h00;
            prev_toggle_r <= 1'b0;
            poll_started_r <= 1'b0;
            cmd_ready_o <= 1'b0;
            byte_ready_o <= 1'b0;
            done_o <= 1'b0;
            error_o <= 1'b0;
            rdata_o <= 8'h00;
            id_high_voltage_address_line_o <= 1'b0;
        end else begin
            bc_start_r <= 1'b0;
            done_o <= 1'b0;
            case (state_r)
                S_IDLE: begin
                    cmd_ready_o <= 1'b1;
                    if (cmd_valid_i && cmd_ready_o) begin
                        cmd_ready_o <= 1'b0;
                        error_o <= 1'b0;
                        op_r <= cmd_op_i;
                        step_r <= 3'd0;
                        nsteps_r <= seq_len(cmd_op_i, protect_i);
                        page_r <= {cmd_addr_i[16:7], 7'h00};
                        raddr_r <= cmd_addr_i;
                        if (cmd_op_i == flash_host_pkg::OP_READ || cmd_op_i == flash_host_pkg::OP_HW_ID) begin
                            id_high_voltage_address_line_o <= (cmd_op_i == flash_host_pkg::OP_HW_ID);
                            timer_r <= 32'(flash_host_pkg::ID_PAUSE_CYC);
                            state_r <= S_READ;
                        end else begin
                            timer_r <= 32'(BYTE_WINDOW_CYC);
                            state_r <= (seq_len(cmd_op_i, protect_i) == 3'd0) ? S_LOAD : S_CMD;
                        end
                    end
                end
                S_CMD: begin
                    if (!bc_start_r && step_r < nsteps_r && (step_r == 3'd0 || bc_done)) begin
                        {bc_addr_r, bc_wdata_r} <= seq_step(op_r, step_r);
                        bc_write_r <= 1'b1;
                        bc_start_r <= 1'b1;
                        step_r <= step_r + 3'd1;
                    end else if (bc_done && step_r == nsteps_r) begin
                        timer_r <= (op_r == flash_host_pkg::OP_ERASE) ? 32'(ERASE_CYC) :
                                   (op_r == flash_host_pkg::OP_PAGE || op_r == flash_host_pkg::OP_PROT_ON) ?
                                   32'(BYTE_WINDOW_CYC) : 32'(flash_host_pkg::ID_PAUSE_CYC);
                        state_r <= (op_r == flash_host_pkg::OP_PAGE || op_r == flash_host_pkg::OP_PROT_ON) ?
                                   S_LOAD : S_PAUSE;
                    end
                end
                S_LOAD: begin
                    // bytes in any order, page address fixed, strobes well inside the window
                    byte_ready_o <= 1'b1;
                    if (byte_valid_i && byte_ready_o) begin
                        byte_ready_o <= 1'b0;
                        bc_addr_r <= {page_r[16:7], byte_offset_i};
                        bc_wdata_r <= byte_data_i;
                        last_data_r <= byte_data_i;
                        raddr_r <= {page_r[16:7], byte_offset_i};
                        bc_write_r <= 1'b1;
                        bc_start_r <= 1'b1;
                        step_r <= {2'b00, byte_last_i};
                        timer_r <= 32'(BYTE_WINDOW_CYC);
                        state_r <= S_WAIT_BYTE;
                    end else if (timer_r > 32'h0000_0000) begin
                        timer_r <= timer_r - 32'h0000_0001;
                        if (timer_r == 32'h0000_0001) begin
                            error_o <= 1'b1;
                            state_r <= S_FINISH;
                        end
                    end
                end
                S_WAIT_BYTE: begin
                    timer_r <= timer_r - 32'h0000_0001;
                    if (bc_done) begin
                        if (step_r[0]) begin
                            // let the load window close, then poll for the end of programming
                            timer_r <= 32'(LOAD_TIMEOUT_CYC);
                            polls_r <= 32'h0000_0000;
                            poll_started_r <= 1'b0;
                            state_r <= S_POLL;
                        end else begin
                            state_r <= S_LOAD;
                        end
                    end
                end
                S_POLL: begin
                    if (timer_r > 32'h0000_0000) begin
                        timer_r <= timer_r - 32'h0000_0001;
                    end else if (!bc_start_r && (!poll_started_r || bc_done)) begin
                        if (poll_started_r && bc_rdata[7] == last_data_r[7] &&
                            bc_rdata[6] == prev_toggle_r) begin
                            state_r <= S_FINISH;
                        end else if (polls_r == 32'(POLL_LIMIT)) begin
                            error_o <= 1'b1;
                            state_r <= S_FINISH;
                        end else begin
                            if (poll_started_r) begin
                                prev_toggle_r <= bc_rdata[6];
                            end
                            poll_started_r <= 1'b1;
                            polls_r <= polls_r + 32'h0000_0001;
                            bc_addr_r <= raddr_r;
                            bc_write_r <= 1'b0;
                            bc_start_r <= 1'b1;
                        end
                    end
                end
                S_PAUSE: begin
                    if (timer_r > 32'h0000_0000) begin
                        timer_r <= timer_r - 32'h0000_0001;
                    end else begin
                        state_r <= S_FINISH;
                    end
                end
                S_READ: begin
                    // high-voltage line settles before the access
                    if (timer_r > 32'h0000_0000 && id_high_voltage_address_line_o) begin
                        timer_r <= timer_r - 32'h0000_0001;
                    end else if (!bc_start_r && !poll_started_r) begin
                        bc_addr_r <= raddr_r;
                        bc_write_r <= 1'b0;
                        bc_start_r <= 1'b1;
                        poll_started_r <= 1'b1;
                    end else if (bc_done) begin
                        rdata_o <= bc_rdata;
                        poll_started_r <= 1'b0;
                        id_high_voltage_address_line_o <= 1'b0;
                        state_r <= S_FINISH;
                    end
                end
                S_FINISH: begin
                    done_o <= 1'b1;
                    byte_ready_o <= 1'b0;
                    poll_started_r <= 1'b0;
                    state_r <= S_IDLE;
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end
endmodule : flash_host_ctrl
`default_nettype wire

// ==== src/flash_host_pkg.sv ====
// constants, opcodes and timing for the parallel page flash host controller
package flash_host_pkg;
    localparam int ADDR_W = 17;
    localparam int PAGE_BYTES = 128;
    localparam int CLK_MHZ = 10;
    localparam logic [16:0] ADDR_5555 = 17'h0_5555;
    localparam logic [16:0] ADDR_2AAA = 17'h0_2aaa;
    localparam logic [7:0] DATA_AA = 8'haa;
    localparam logic [7:0] DATA_55 = 8'h55;
    localparam logic [7:0] DATA_A0 = 8'ha0;
    localparam logic [7:0] DATA_80 = 8'h80;
    localparam logic [7:0] DATA_20 = 8'h20;
    localparam logic [7:0] DATA_10 = 8'h10;
    localparam logic [7:0] DATA_60 = 8'h60;
    localparam logic [7:0] DATA_F0 = 8'hf0;
    // opcodes of the host command port
    localparam logic [2:0] OP_READ = 3'h0;
    localparam logic [2:0] OP_PAGE = 3'h1;
    localparam logic [2:0] OP_PROT_ON = 3'h2;
    localparam logic [2:0] OP_PROT_OFF = 3'h3;
    localparam logic [2:0] OP_ERASE = 3'h4;
    localparam logic [2:0] OP_ID_ENTER = 3'h5;
    localparam logic [2:0] OP_ID_EXIT = 3'h6;
    localparam logic [2:0] OP_HW_ID = 3'h7;
    // timing, in ns, us, ms and cycles
    localparam int CLK_NS = 1000 / CLK_MHZ;
    localparam int STROBE_NS = 200;
    localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int READ_NS = 200;
    localparam int READ_CYC = (READ_NS + CLK_NS - 1) / CLK_NS;
    localparam int READ_SYNC_CYC = 3;
    localparam int BYTE_WINDOW_US = 200;
    localparam int BYTE_WINDOW_CYC = BYTE_WINDOW_US * CLK_MHZ;
    localparam int LOAD_TIMEOUT_US = 300;
    localparam int LOAD_TIMEOUT_CYC = LOAD_TIMEOUT_US * CLK_MHZ;
    localparam int ID_PAUSE_US = 10;
    localparam int ID_PAUSE_CYC = ID_PAUSE_US * CLK_MHZ;
    localparam int ERASE_MS = 50;
    localparam int ERASE_CYC = ERASE_MS * 1000 * CLK_MHZ;
    localparam int POLL_LIMIT = 1_000_000;
endpackage : flash_host_pkg

// ==== src/flash_bus_cycle.sv ====
// one timed write or read strobe on the flash pins
`timescale 1ns/1ps
`default_nettype none
module flash_bus_cycle (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // request
    input wire logic start_i,
    input wire logic write_i,
    input wire logic [16:0] addr_i,
    input wire logic [7:0] wdata_i,
    // result
    output logic done_o,
    output logic [7:0] rdata_o,
    // flash pins
    output logic [16:0] addr_o,
    output logic [7:0] dq_o,
    output logic dq_oe_o,
    output logic ce_n_o,
    output logic oe_n_o,
    output logic we_n_o,
    input wire logic [7:0] dq_i
);
    typedef enum logic [3:0] {
        B_IDLE = 4'b0001,
        B_SETUP = 4'b0010,
        B_STROBE = 4'b0100,
        B_HOLD = 4'b1000
    } bus_state_t;
    bus_state_t state_r;
    logic write_r;
    logic [7:0] cnt_r;
    logic [7:0] s1_r, s2_r, s3_r;

    // three-stage capture of the data pins
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s1_r <= 8'h00;
            s2_r <= 8'h00;
            s3_r <= 8'h00;
        end else begin
            s1_r <= dq_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_r <= B_IDLE;
            write_r <= 1'b0;
            cnt_r <= 8'h00;
            done_o <= 1'b0;
            rdata_o <= 8'h00;
            addr_o <= 17'h0_0000;
            dq_o <= 8'h00;
            dq_oe_o <= 1'b0;
            ce_n_o <= 1'b1;
            oe_n_o <= 1'b1;
            we_n_o <= 1'b1;
        end else begin
            done_o <= 1'b0;
            case (state_r)
                B_IDLE: begin
                    if (start_i) begin
                        write_r <= write_i;
                        addr_o <= addr_i;
                        dq_o <= wdata_i;
                        dq_oe_o <= write_i;
                        ce_n_o <= 1'b0;
                        state_r <= B_SETUP;
                    end
                end
                B_SETUP: begin
                    // write: ce and we low, oe high; address latched on the later fall
                    we_n_o <= ~write_r;
                    oe_n_o <= write_r;
                    // read strobe also spans the registered output enable and the capture stages
                    cnt_r <= write_r ? 8'(flash_host_pkg::STROBE_CYC) :
                             8'(flash_host_pkg::READ_CYC + flash_host_pkg::READ_SYNC_CYC);
                    state_r <= B_STROBE;
                end
                B_STROBE: begin
                    // strobe well above the glitch filter
                    if (cnt_r > 8'h01) begin
                        cnt_r <= cnt_r - 8'h01;
                    end else begin
                        if (!write_r) begin
                            rdata_o <= (s2_r == s3_r) ? s3_r : s2_r;
                        end
                        we_n_o <= 1'b1;
                        oe_n_o <= 1'b1;
                        state_r <= B_HOLD;
                    end
                end
                B_HOLD: begin
                    ce_n_o <= 1'b1;
                    dq_oe_o <= 1'b0;
                    done_o <= 1'b1;
                    state_r <= B_IDLE;
                end
                default: state_r <= B_IDLE;
            endcase
        end
    end
endmodule : flash_bus_cycle
`default_nettype wire

// ==== testbench/flash_host_sva.sv ====
// assertion checker on the flash host controller pins
`timescale 1ns/1ps
`default_nettype none
module flash_host_sva (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // page stream and results
    input wire logic byte_valid_i,
    input wire logic byte_ready_o,
    input wire logic done_o,
    input wire logic error_o,
    // flash pins
    input wire logic [16:0] address_lines_o,
    input wire logic [7:0] data_lines_o,
    input wire logic data_lines_oe_o,
    input wire logic chip_enable_n_o,
    input wire logic output_enable_n_o,
    input wire logic write_enable_n_o,
    input wire logic id_high_voltage_address_line_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_read_no_drive: assert property (!output_enable_n_o |-> !data_lines_oe_o)
        else $error("host drives data during read");
    a_drive_selected: assert property (data_lines_oe_o |-> !chip_enable_n_o)
        else $error("host drives data while deselected");
    a_write_select: assert property (!write_enable_n_o |-> !chip_enable_n_o && output_enable_n_o)
        else $error("write strobe without proper selects");
    a_read_no_write: assert property (!output_enable_n_o |-> write_enable_n_o)
        else $error("read and write strobes together");
    a_we_min_width: assert property ($fell(write_enable_n_o) |-> !write_enable_n_o [*2])
        else $error("write strobe too short");
    a_addr_stable: assert property (!chip_enable_n_o && $past(!chip_enable_n_o) |-> $stable(address_lines_o))
        else $error("address moved while selected");
    a_data_held: assert property (!write_enable_n_o |-> data_lines_oe_o && $stable(data_lines_o))
        else $error("write data not held");
    a_byte_to_write: assert property (byte_valid_i && byte_ready_o |-> ##[1:20] $fell(write_enable_n_o))
        else $error("byte not written in time");
    a_hv_no_write: assert property (id_high_voltage_address_line_o |-> write_enable_n_o)
        else $error("write during id voltage");
    c_write: cover property ($fell(write_enable_n_o));
    c_error: cover property (error_o && done_o);
    c_hv: cover property (id_high_voltage_address_line_o && !output_enable_n_o);
endmodule : flash_host_sva
bind flash_host_ctrl flash_host_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .byte_valid_i(byte_valid_i),
    .byte_ready_o(byte_ready_o), .done_o(done_o), .error_o(error_o), .address_lines_o(address_lines_o),
    .data_lines_o(data_lines_o), .data_lines_oe_o(data_lines_oe_o), .chip_enable_n_o(chip_enable_n_o),
    .output_enable_n_o(output_enable_n_o), .write_enable_n_o(write_enable_n_o),
    .id_high_voltage_address_line_o(id_high_voltage_address_line_o));
`default_nettype wire

// ==== testbench/flash_model.sv ====
// behavioural model of the parallel page flash device
`timescale 1ns/1ps
`default_nettype none
module flash_model #(
    parameter real TO_NS = 5000.0,
    parameter real PROG_NS = 20000.0,
    parameter real ERASE_NS = 15000.0,
    parameter logic [7:0] MAKER_ID = 8'h3c, // arbitrary value
    parameter logic [7:0] PART_ID = 8'h5a // arbitrary value
) (
    // flash pins
    input wire logic ce_n_i,
    input wire logic oe_n_i,
    input wire logic we_n_i,
    input wire logic hv_i,
    input wire logic [16:0] addr_i,
    input wire logic [7:0] dq_i,
    output logic [7:0] dq_o
);
    logic [7:0] mem [int];
    logic [7:0] pbuf [128];
    logic [7:0] v, last_d;
    logic [9:0] pg;
    logic [16:0] la;
    logic prot = 1'b1;
    logic loading = 0, busy = 0, erasing = 0, idm = 0, tog = 0;
    int step = 0;
    realtime tf = -1.0, t_last, t_busy;
    wire logic wr_n = ce_n_i | we_n_i | ~oe_n_i;
    task automatic open_load();
        loading = 1;
        t_last = $realtime;
        foreach (pbuf[i]) pbuf[i] = 8'hff;
    endtask : open_load
    task automatic wr(input logic [16:0] a, input logic [7:0] d);
        logic a5, a2;
        a5 = a == 17'h0_5555;
        a2 = a == 17'h0_2aaa;
        if (busy) return;
        if (loading) begin
            pbuf[a[6:0]] = d;
            pg = a[16:7];
            last_d = d;
            t_last = $realtime;
        end else if ((a5 && d == 8'haa && step % 3 == 0) || (a2 && d == 8'h55 && step % 3 == 1)) begin
            step++;
        end else if (a5 && step == 2 && d == 8'h80) begin
            step = 3;
        end else if (a5 && step == 2 && d == 8'ha0) begin
            prot = 1;
            step = 0;
            open_load();
        end else if (a5 && step == 2 && d == 8'hf0) begin
            idm = 0;
            step = 0;
        end else if (a5 && step == 5 && d inside {8'h20, 8'h10, 8'h60}) begin
            prot = prot && d != 8'h20;
            idm = d == 8'h60;
            erasing = d == 8'h10;
            busy = erasing;
            t_busy = $realtime;
            step = 0;
        end else begin
            step = 0;
            if (!prot) begin
                open_load();
                wr(a, d);
            end
        end
    endtask : wr
    always #50 begin
        if (loading && $realtime - t_last > TO_NS) begin
            loading = 0;
            busy = 1;
            t_busy = $realtime;
        end
        if (busy && $realtime - t_busy > (erasing ? ERASE_NS : PROG_NS)) begin
            if (erasing) mem.delete();
            else foreach (pbuf[i]) mem[{pg, i[6:0]}] = pbuf[i];
            busy = 0;
            erasing = 0;
        end
    end
    always @(negedge wr_n) begin
        la = addr_i;
        tf = $realtime;
    end
    always @(posedge wr_n) if (tf >= 0.0 && $realtime - tf >= 15.0) wr(la, dq_i);
    always @(posedge (ce_n_i | oe_n_i)) if (busy) tog = ~tog;
    always @* begin
        if (hv_i) v = addr_i[0] ? PART_ID : MAKER_ID;
        else if (busy) v = {~last_d[7], tog, 6'h00};
        else if (idm && addr_i[16:1] == 16'h0000) v = addr_i[0] ? PART_ID : MAKER_ID;
        else v = mem.exists(addr_i) ? mem[addr_i] : 8'hff;
        dq_o = (!ce_n_i && !oe_n_i) ? v : ~v;
    end
endmodule : flash_model
`default_nettype wire

// ==== testbench/testbench.sv ====
// self-checking testbench for the flash host controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam logic [7:0] MAKER = 8'h3c; // arbitrary value
    localparam logic [7:0] PART = 8'h5a; // arbitrary value
    logic clk_i = 0, rst_i = 1, cmd_valid_i = 0, protect_i = 0, byte_valid_i = 0, byte_last_i = 0;
    logic [2:0] cmd_op_i = 3'h0;
    logic [16:0] cmd_addr_i = 17'h0_0000, address_lines_o;
    logic [7:0] cmd_data_i = 8'h00, byte_data_i = 8'h00, rdata_o, data_lines_o, flash_dq;
    logic [6:0] byte_offset_i = 7'h00;
    logic cmd_ready_o, byte_ready_o, done_o, error_o, data_lines_oe_o, ce_n, oe_n, we_n, hv;
    wire logic [7:0] bus = data_lines_oe_o ? data_lines_o : flash_dq;
    int fails = 0, checks_done = 0;
    logic [9:0] notes [$];
    logic [7:0] exp_mem [int];
    flash_host_ctrl #(.BYTE_WINDOW_CYC(50), .LOAD_TIMEOUT_CYC(100), .ERASE_CYC(200), .POLL_LIMIT(1000)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i), .cmd_addr_i(cmd_addr_i),
        .cmd_data_i(cmd_data_i), .protect_i(protect_i), .cmd_ready_o(cmd_ready_o), .byte_valid_i(byte_valid_i),
        .byte_offset_i(byte_offset_i), .byte_data_i(byte_data_i), .byte_last_i(byte_last_i),
        .byte_ready_o(byte_ready_o), .done_o(done_o), .error_o(error_o), .rdata_o(rdata_o),
        .address_lines_o(address_lines_o), .data_lines_o(data_lines_o), .data_lines_oe_o(data_lines_oe_o),
        .data_lines_i(bus), .chip_enable_n_o(ce_n), .output_enable_n_o(oe_n), .write_enable_n_o(we_n),
        .id_high_voltage_address_line_o(hv));
    flash_model #(.MAKER_ID(MAKER), .PART_ID(PART)) flash (.ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n),
        .hv_i(hv), .addr_i(address_lines_o), .dq_i(bus), .dq_o(flash_dq));
    initial forever #50 clk_i = ~clk_i;
    task automatic bad(input string m);
        fails++;
        $display("BAD %0t %s", $time, m);
    endtask : bad
    task automatic end_sim();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_sim
    task automatic cmd(input logic [2:0] op, input logic [16:0] a, input logic [9:0] note);
        notes.push_back(note);
        cmd_op_i <= op;
        cmd_addr_i <= a;
        cmd_valid_i <= 1;
        do @(posedge clk_i); while (cmd_ready_o !== 1'b1);
        cmd_valid_i <= 0;
    endtask : cmd
    task automatic wait_done();
        int n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (done_o !== 1'b1 && n < 20000);
        if (done_o !== 1'b1) bad("no completion");
    endtask : wait_done
    task automatic rd(input logic [16:0] a, input logic [7:0] e, input logic [2:0] op = flash_host_pkg::OP_READ);
        cmd(op, a, {2'b10, e});
        wait_done();
    endtask : rd
    task automatic page(input logic [2:0] op, input logic [16:0] base, input logic p);
        int k, s, st, o;
        logic [7:0] d;
        k = $urandom_range(20, 40);
        s = $urandom_range(0, 127);
        st = 2 * $urandom_range(1, 63) + 1;
        protect_i <= p;
        cmd(op, base, 10'h000);
        for (int b = 0; b < 128; b++) exp_mem[{base[16:7], 7'(b)}] = 8'hff;
        for (int i = 0; i < k; i++) begin
            d = 8'($urandom);
            o = (s + i * st) % 128;
            exp_mem[{base[16:7], 7'(o)}] = d;
            byte_offset_i <= 7'(o);
            byte_data_i <= d;
            byte_last_i <= i == k - 1;
            byte_valid_i <= 1;
            do @(posedge clk_i); while (byte_ready_o !== 1'b1);
            byte_valid_i <= 0;
            repeat ($urandom_range(1, 3)) @(posedge clk_i);
        end
        wait_done();
        for (int b = 0; b < 128; b++) rd({base[16:7], 7'(b)}, exp_mem[{base[16:7], 7'(b)}]);
        $display("test page %h done", base);
    endtask : page
    always @(posedge clk_i) begin
        logic [9:0] e;
        if (!rst_i && done_o === 1'b1) begin
            checks_done++;
            if (notes.size() == 0) bad("unexpected completion");
            else begin
                e = notes.pop_front();
                if (e[9] && rdata_o !== e[7:0]) bad("read data");
                if (error_o !== e[8]) bad("error flag");
            end
        end
    end
    initial begin
        #(60000 * 100);
        bad("watchdog");
        end_sim();
    end
    initial begin
        void'($urandom(64648));
        repeat (10) @(posedge clk_i);
        rst_i <= 0;
        repeat (2) @(posedge clk_i);
        rd(17'h1_2345, 8'hff);
        rd(17'h0_0000, MAKER, flash_host_pkg::OP_HW_ID);
        rd(17'h0_0001, PART, flash_host_pkg::OP_HW_ID);
        $display("test reads done");
        page(flash_host_pkg::OP_PROT_ON, 17'h1_2300, 1'b1);
        page(flash_host_pkg::OP_PAGE, 17'h0_0080, 1'b1);
        cmd(flash_host_pkg::OP_PROT_OFF, 17'h0_0000, 10'h000);
        wait_done();
        page(flash_host_pkg::OP_PAGE, 17'h1_ff80, 1'b0);
        cmd(flash_host_pkg::OP_ID_ENTER, 17'h0_0000, 10'h000);
        wait_done();
        rd(17'h0_0000, MAKER);
        rd(17'h0_0001, PART);
        cmd(flash_host_pkg::OP_ID_EXIT, 17'h0_0000, 10'h000);
        wait_done();
        rd(17'h0_0001, 8'hff);
        $display("test id done");
        cmd(flash_host_pkg::OP_ERASE, 17'h0_0000, 10'h000);
        wait_done();
        rd(17'h1_2300 + 17'(s_off()), 8'hff);
        rd(17'h1_ff80, 8'hff);
        $display("test erase done");
        cmd(flash_host_pkg::OP_PAGE, 17'h0_0100, 10'h100);
        wait_done();
        rd(17'h0_0100, 8'hff);
        $display("test window done");
        end_sim();
    end
    function automatic int s_off();
        return $urandom_range(0, 127);
    endfunction : s_off
endmodule : testbench
`default_nettype wire
